// ==== core/tcc_top.sv ====
// Six-channel capture/compare/PWM timer with an AXI4-Lite register slave.
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`include "tcc_params.svh"
module tcc_top import tcc_pkg::*; #(
  parameter int NCH = `TCC_NUM_CHAN,
  parameter int CW = 16
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Channel pins and interrupt requests.
  input wire logic [NCH-1:0] channel_pin_in,
  output logic [NCH-1:0] channel_pin_out,
  output logic [NCH-1:0] channel_pin_oe,
  output logic [NCH-1:0] channel_irq
);
  // Map a byte address onto a register kind and channel index.
  function automatic tcc_dec_type decode(input logic [7:0] a);
    tcc_dec_type d;
    logic [7:0] off;
    d.kind = TCC_R_NONE;
    d.chan = 3'h0;
    off = 8'h00;
    if (a[1:0] != 2'h0) begin
      d.kind = TCC_R_NONE;
    end else if (a == `TCC_OFS_TCTRL) begin
      d.kind = TCC_R_TCTRL;
    end else if (a == `TCC_OFS_MOD) begin
      d.kind = TCC_R_MOD;
    end else if (a == `TCC_OFS_CNT) begin
      d.kind = TCC_R_CNT;
    end else if (a >= `TCC_OFS_CHCTL && a <= `TCC_OFS_CHCTL_END) begin
      off = a - `TCC_OFS_CHCTL;
      d.kind = TCC_R_CHCTL;
      d.chan = off[4:2];
    end else if (a >= `TCC_OFS_VAL && a <= `TCC_OFS_VAL_END) begin
      off = a - `TCC_OFS_VAL;
      d.kind = off[2] ? TCC_R_VLO : TCC_R_VHI;
      d.chan = off[5:3];
    end
    return d;
  endfunction

  // Bus slave state.
  logic awready_r;
  logic wready_r;
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // Counter state.
  logic halt_r;
  logic [CW-1:0] mod_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic step_r;

  // Per-channel state.
  tcc_cfg_type cfg_r [NCH];
  logic [NCH-1:0] flag_r;
  logic [NCH-1:0] arm_r;
  logic [NCH-1:0] cap_lock_r;
  logic [NCH-1:0] cmp_lock_r;
  logic [CW-1:0] val_r [NCH];
  logic [NCH-1:0] irq_r;
  logic [NCH-1:0] cap_evt;
  logic [NCH-1:0] cmp_evt;
  logic [NCH-1:0] disabled;
  logic [NCH-1:0] pin_out_w;
  logic [NCH-1:0] pin_oe_w;
  logic [CW-1:0] partner [NCH];

  // Pin synchroniser: three stages, a change counts when the last two agree.
  logic [NCH-1:0] sync1_r;
  logic [NCH-1:0] sync2_r;
  logic [NCH-1:0] sync3_r;
  logic [NCH-1:0] level_r;

  // Handshake decode.
  wire aw_take = s_axi_awvalid & awready_r;
  wire w_take = s_axi_wvalid & wready_r;
  wire wr_do = aw_held_r & w_held_r & ~bvalid_r;
  wire aw_held_nxt = (aw_held_r | aw_take) & ~wr_do;
  wire w_held_nxt = (w_held_r | w_take) & ~wr_do;
  wire ar_take = s_axi_arvalid & arready_r;
  wire rd_busy_nxt = ar_take | (rvalid_r & ~s_axi_rready);
  wire tcc_dec_type wdec = decode(awaddr_r);
  wire tcc_dec_type rdec = decode(s_axi_araddr);
  wire wmap = wdec.kind != TCC_R_NONE &&
              !(wdec.kind inside {TCC_R_CHCTL, TCC_R_VHI, TCC_R_VLO} &&
                wdec.chan >= NCH[2:0]);
  wire rmap = rdec.kind != TCC_R_NONE &&
              !(rdec.kind inside {TCC_R_CHCTL, TCC_R_VHI, TCC_R_VLO} &&
                rdec.chan >= NCH[2:0]);
  wire [7:0] wb = wdata_r[7:0];
  wire [7:0] wb1 = wdata_r[15:8];
  wire wr_ok = wr_do & wmap;
  wire rd_ok = ar_take & rmap;

  // Counter control strobes.
  wire cnt_clr = wr_ok & wdec.kind == TCC_R_TCTRL & wstrb_r[0] &
                 wb[`TCC_BIT_CLEAR];
  wire ovf = ~halt_r & ~cnt_clr & (cnt_r == mod_r);

  // Counter next value; the clear strobe also restarts a running count.
  always_comb begin
    if (cnt_clr) begin
      cnt_nxt = '0;
    end else if (halt_r) begin
      cnt_nxt = cnt_r;
    end else if (ovf) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  // Read data selection.
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    case (rdec.kind)
      TCC_R_TCTRL: rd_data[`TCC_BIT_HALT] = halt_r;
      TCC_R_MOD: rd_data[CW-1:0] = mod_r;
      TCC_R_CNT: rd_data[CW-1:0] = cnt_r;
      TCC_R_CHCTL: begin
        if (rmap) begin
          rd_data[7:0] = {flag_r[rdec.chan], cfg_r[rdec.chan]};
        end
      end
      TCC_R_VHI: begin
        if (rmap) begin
          rd_data[7:0] = val_r[rdec.chan][15:8];
        end
      end
      TCC_R_VLO: begin
        if (rmap) begin
          rd_data[7:0] = val_r[rdec.chan][7:0];
        end
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Write channel of the bus; address and data may arrive in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `TCC_RESP_OKAY;
    end else begin
      awready_r <= ~aw_held_nxt;
      wready_r <= ~w_held_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      if (aw_take) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_do) begin
        bvalid_r <= 1'b1;
        bresp_r <= wmap ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read channel: data are sampled at the address handshake.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `TCC_RESP_OKAY;
    end else begin
      arready_r <= ~rd_busy_nxt;
      rvalid_r <= rd_busy_nxt;
      if (ar_take) begin
        rdata_r <= rd_data;
        rresp_r <= rmap ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
      end
    end
  end

  // Shared counter, halt bit and modulo value.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halt_r <= `TCC_RST_HALT;
      mod_r <= `TCC_RST_MOD;
      cnt_r <= '0;
      step_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      step_r <= ~halt_r | cnt_clr;
      if (wr_ok && wdec.kind == TCC_R_TCTRL && wstrb_r[0]) begin
        halt_r <= wb[`TCC_BIT_HALT];
      end
      if (wr_ok && wdec.kind == TCC_R_MOD) begin
        if (wstrb_r[0]) begin
          mod_r[7:0] <= wb;
        end
        if (wstrb_r[1]) begin
          mod_r[15:8] <= wb1;
        end
      end
    end
  end

  // Pin inputs cross into the clock domain before any edge logic.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      level_r <= '0;
    end else begin
      sync1_r <= channel_pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      level_r <= (sync2_r & sync3_r) | (level_r & (sync2_r ^ sync3_r));
    end
  end

  // Per-channel registers and channel logic.
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    localparam bit EVEN = (i % 2) == 0;
    wire ctl_sel = wdec.kind == TCC_R_CHCTL && wdec.chan == i[2:0];
    wire ctl_wr = wr_ok & ctl_sel & wstrb_r[0] & ~disabled[i];
    wire ctl_rd = rd_ok & rdec.kind == TCC_R_CHCTL &&
                  rdec.chan == i[2:0];
    wire hi_wr = wr_ok & wstrb_r[0] & wdec.kind == TCC_R_VHI &&
                 wdec.chan == i[2:0];
    wire lo_wr = wr_ok & wstrb_r[0] & wdec.kind == TCC_R_VLO &&
                 wdec.chan == i[2:0];
    wire hi_rd = rd_ok & rdec.kind == TCC_R_VHI && rdec.chan == i[2:0];
    wire lo_rd = rd_ok & rdec.kind == TCC_R_VLO && rdec.chan == i[2:0];
    wire evt = cap_evt[i] | cmp_evt[i];
    wire flag_clr = ctl_wr & ~wb[`TCC_BIT_FLAG] & arm_r[i];
    wire cap_mode = ~cfg_r[i].buf_sel & ~cfg_r[i].unbuf_sel;

    if (EVEN && i + 1 < NCH) begin : g_link
      assign partner[i] = val_r[i+1];
    end else begin : g_nolink
      assign partner[i] = val_r[i];
    end
    if (!EVEN) begin : g_odd
      assign disabled[i] = cfg_r[i-1].buf_sel;
    end else begin : g_even
      assign disabled[i] = 1'b0;
    end

    // Flag and its two-step clear; a new event beats the clearing write.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        flag_r[i] <= 1'b0;
        arm_r[i] <= 1'b0;
        cfg_r[i] <= '0;
        irq_r[i] <= 1'b0;
        cap_lock_r[i] <= 1'b0;
        cmp_lock_r[i] <= 1'b0;
      end else begin
        flag_r[i] <= evt | (flag_r[i] & ~flag_clr);
        if (evt || flag_clr) begin
          arm_r[i] <= 1'b0;
        end else if (ctl_rd && flag_r[i]) begin
          arm_r[i] <= 1'b1;
        end
        if (ctl_wr) begin
          cfg_r[i].irq_en <= wb[`TCC_BIT_IRQ_EN];
          cfg_r[i].buf_sel <= EVEN & wb[`TCC_BIT_BUF_SEL];
          cfg_r[i].unbuf_sel <= wb[`TCC_BIT_UNBUF_SEL];
          cfg_r[i].els <= {wb[`TCC_BIT_ELS_HI], wb[`TCC_BIT_ELS_LO]};
          cfg_r[i].tov <= wb[`TCC_BIT_TOV];
          cfg_r[i].full_duty <= wb[`TCC_BIT_FULL];
        end
        irq_r[i] <= flag_r[i] & cfg_r[i].irq_en;
        if (lo_rd) begin
          cap_lock_r[i] <= 1'b0;
        end else if (hi_rd && cap_mode) begin
          cap_lock_r[i] <= 1'b1;
        end
        if (lo_wr) begin
          cmp_lock_r[i] <= 1'b0;
        end else if (hi_wr && !cap_mode) begin
          cmp_lock_r[i] <= 1'b1;
        end
      end
    end

    // Value registers have no reset; a capture overrides a same-cycle write.
    always_ff @(posedge aclk) begin
      if (cap_evt[i]) begin
        val_r[i] <= cnt_r;
      end else begin
        if (hi_wr) begin
          val_r[i][15:8] <= wb;
        end
        if (lo_wr) begin
          val_r[i][7:0] <= wb;
        end
      end
    end

    tcc_channel #(
      .IS_EVEN(EVEN),
      .CW(CW)
    ) u_chan (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(cfg_r[i]),
      .disabled(disabled[i]),
      .cnt(cnt_r),
      .step(step_r),
      .ovf(ovf),
      .halt(halt_r),
      .value(val_r[i]),
      .partner_value(partner[i]),
      .cap_block(cap_lock_r[i]),
      .cmp_block(cmp_lock_r[i]),
      .pin_level(level_r[i]),
      .cap_evt(cap_evt[i]),
      .cmp_evt(cmp_evt[i]),
      .pin_out(pin_out_w[i]),
      .pin_oe(pin_oe_w[i])
    );
  end

  // Outputs straight from flip-flops.
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign channel_pin_out = pin_out_w;
  assign channel_pin_oe = pin_oe_w;
  assign channel_irq = irq_r;
endmodule

// ==== core/tcc_params.svh ====
// Register map, field positions, reset values and response codes of the channel timer.
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH
`define TCC_NUM_CHAN 6
`define TCC_OFS_TCTRL 8'h00
`define TCC_OFS_MOD 8'h04
`define TCC_OFS_CNT 8'h08
`define TCC_OFS_CHCTL 8'h10
`define TCC_OFS_CHCTL_END 8'h24
`define TCC_OFS_VAL 8'h30
`define TCC_OFS_VAL_END 8'h5C
`define TCC_BIT_HALT 5
`define TCC_BIT_CLEAR 4
`define TCC_BIT_FLAG 7
`define TCC_BIT_IRQ_EN 6
`define TCC_BIT_BUF_SEL 5
`define TCC_BIT_UNBUF_SEL 4
`define TCC_BIT_ELS_HI 3
`define TCC_BIT_ELS_LO 2
`define TCC_BIT_TOV 1
`define TCC_BIT_FULL 0
`define TCC_RST_MOD 16'hFFFF
`define TCC_RST_HALT 1'b1
`define TCC_RESP_OKAY 2'h0
`define TCC_RESP_SLVERR 2'h2
`endif

// ==== core/tcc_pkg.sv ====
// Types shared by the channel timer modules.
package tcc_pkg;
  // Kinds of register that an address can select.
  typedef enum logic [2:0] {
    TCC_R_NONE, TCC_R_TCTRL, TCC_R_MOD, TCC_R_CNT,
    TCC_R_CHCTL, TCC_R_VHI, TCC_R_VLO
  } tcc_reg_kind_type;
  // Result of an address decode.
  typedef struct packed {
    tcc_reg_kind_type kind;
    logic [2:0] chan;
  } tcc_dec_type;
  // Software-written configuration of one channel.
  typedef struct packed {
    logic irq_en;
    logic buf_sel;
    logic unbuf_sel;
    logic [1:0] els;
    logic tov;
    logic full_duty;
  } tcc_cfg_type;
endpackage

// ==== core/tcc_channel.sv ====
// One timer channel: capture edge detect, compare match and pin action.
`include "tcc_params.svh"
module tcc_channel import tcc_pkg::*; #(
  parameter bit IS_EVEN = 1'b0,
  parameter int CW = 16
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Configuration and linkage.
  input wire tcc_cfg_type cfg,
  input wire logic disabled,
  // Shared counter.
  input wire logic [CW-1:0] cnt,
  input wire logic step,
  input wire logic ovf,
  input wire logic halt,
  // Value registers and their locks.
  input wire logic [CW-1:0] value,
  input wire logic [CW-1:0] partner_value,
  input wire logic cap_block,
  input wire logic cmp_block,
  // Filtered pin level.
  input wire logic pin_level,
  // Results.
  output logic cap_evt,
  output logic cmp_evt,
  output logic pin_out,
  output logic pin_oe
);
  logic prev_r;
  logic alt_r;
  logic max_r;
  logic pin_r;
  logic oe_r;
  logic pin_nxt;
  wire buffered = IS_EVEN & cfg.buf_sel;
  wire connected = (cfg.els != 2'b00) & ~disabled;
  wire cmp_mode = buffered | cfg.unbuf_sel;
  wire cap_mode = ~cmp_mode & ~disabled;
  wire rise = pin_level & ~prev_r;
  wire fall = ~pin_level & prev_r;
  wire edge_hit = (cfg.els == 2'b01 & rise) | (cfg.els == 2'b10 & fall) |
                  (cfg.els == 2'b11 & (rise | fall));
  wire [CW-1:0] cmp_val = (buffered & alt_r) ? partner_value : value;
  // Capture mode reuses the edge bits, so forcing is limited to compare.
  wire pwm_force = max_r & cfg.tov & cmp_mode & cfg.els == 2'b10;
  wire tov_act = cfg.tov & ovf & cmp_mode;

  // Capture needs a running counter and an unlocked value register.
  assign cap_evt = cap_mode & connected & edge_hit & ~halt & ~cap_block;
  // A match is tested once per counter step so a halted count fires once.
  assign cmp_evt = cmp_mode & ~disabled & step & ~cmp_block &
                   (cnt == cmp_val);

  // Pin level: overflow toggle outranks a compare action in the same cycle.
  always_comb begin
    pin_nxt = pin_r;
    if (!connected) begin
      pin_nxt = ~cfg.unbuf_sel;
    end else if (pwm_force) begin
      pin_nxt = 1'b1;
    end else if (tov_act) begin
      pin_nxt = ~pin_r;
    end else if (cmp_evt) begin
      case (cfg.els)
        2'b01: pin_nxt = ~pin_r;
        2'b10: pin_nxt = 1'b0;
        2'b11: pin_nxt = 1'b1;
        default: pin_nxt = pin_r;
      endcase
    end
  end

  // Edge history, buffer select, full-duty latch and pin drive.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 1'b0;
      alt_r <= 1'b0;
      max_r <= 1'b0;
      pin_r <= 1'b1;
      oe_r <= 1'b0;
    end else begin
      prev_r <= pin_level;
      if (!buffered) begin
        alt_r <= 1'b0;
      end else if (ovf) begin
        alt_r <= ~alt_r;
      end
      if (ovf) begin
        max_r <= cfg.full_duty;
      end
      pin_r <= pin_nxt;
      oe_r <= connected & cmp_mode;
    end
  end

  assign pin_out = pin_r;
  assign pin_oe = oe_r;
endmodule

// ==== tb/tcc_top_monitor.sv ====
// Concurrent checks on the register bus and pins of the channel timer.
`include "tcc_params.svh"
module tcc_top_monitor #(
  parameter int NCH = 6
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins and requests.
  input wire logic [NCH-1:0] channel_pin_out,
  input wire logic [NCH-1:0] channel_pin_oe,
  input wire logic [NCH-1:0] channel_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] resp_hist_r;
  wire logic recent_wr;
  default clocking mon_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Settings change only by a write, so a response lies a few cycles back.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resp_hist_r <= '0;
    end else begin
      resp_hist_r <= {resp_hist_r[1:0], s_axi_bvalid};
    end
  end
  assign recent_wr = s_axi_bvalid | (|resp_hist_r);
  // Reset silences requests, drivers and answers.
  rst_quiet_a: assert property (disable iff (1'b0)
    !aresetn |=> channel_irq == '0 && channel_pin_oe == '0
      && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  // Bus answers come on time and stand until taken.
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read answer late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr > `TCC_OFS_VAL_END |=> s_axi_rresp == `TCC_RESP_SLVERR)
    else $error("unmapped read not refused");
  // Pin ownership, preset levels and request drops follow writes only.
  oe_cause_a: assert property (
    $changed(channel_pin_oe) |-> recent_wr)
    else $error("pin drive changed without a write");
  irq_fall_a: assert property (
    |($past(channel_irq) & ~channel_irq) |-> recent_wr)
    else $error("request dropped without a write");
  preset_pin_a: assert property (
    |((channel_pin_out ^ $past(channel_pin_out)) & ~channel_pin_oe
      & ~$past(channel_pin_oe)) |-> recent_wr)
    else $error("preset level changed without a write");
endmodule

// ==== tb/tcc_pin_model.sv ====
// Outside world at the channel pins: sources that meet the pin drivers.
module tcc_pin_model #(
  parameter int NCH = 6
) (
  // Level the outside source wants on each pin.
  input wire logic [NCH-1:0] drive,
  // Timer side of the pins.
  input wire logic [NCH-1:0] pin_out,
  input wire logic [NCH-1:0] pin_oe,
  output logic [NCH-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // A driving timer wins; the outside source is weak, like a resistor.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive);
endmodule

// ==== tb/tcc_top_tb.sv ====
// Self-checking bench for the six-channel capture/compare timer.
`include "tcc_params.svh"
module tcc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NCH = `TCC_NUM_CHAN;
  localparam logic [7:0] TC = `TCC_OFS_TCTRL;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, p;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, rsp;
  logic [NCH-1:0] drive = '0;
  logic [NCH-1:0] pin_in, pin_out, pin_oe, irq;
  logic [15:0] v;
  int seed = 29, n_errors = 0, checks = 0, n;
  // Free-running clock of 100 ns period.
  always #50 aclk = ~aclk;
  tcc_top tcc_top_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .channel_pin_in(pin_in), .channel_pin_out(pin_out),
    .channel_pin_oe(pin_oe), .channel_irq(irq));
  tcc_pin_model #(.NCH(NCH)) tcc_pin_model_inst (.drive(drive),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
  // Register addresses and expected capture results.
  function automatic logic [7:0] ctl(input int i);
    return `TCC_OFS_CHCTL + 8'(4 * i);
  endfunction
  function automatic logic [7:0] vh(input int i);
    return `TCC_OFS_VAL + 8'(8 * i);
  endfunction
  function automatic logic hit(input int e, input int k);
    return (k != 2) && ((k == 1) ? e[0] : e[1]);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge aclk);
    #1;
  endtask
  // Bus cycles; a response is accepted a cycle late to exercise holding.
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    int t;
    t = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready) && t < 40);
    rsp = bresp;
    bready <= 1'b0;
    if (t >= 40) n_errors++;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    int t;
    t = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready) && t < 40);
    q = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (t >= 40) n_errors++;
  endtask
  task automatic results();
    $display("checks %0d, errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence; the counter is halted and cleared before mode changes, except for the full-duty step.
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    settle(2);
    for (int i = 0; i < NCH; i++) begin
      rd(ctl(i), d);
      chk(d, 32'h0);
      wr(ctl(i), 32'h20);
      rd(ctl(i), d);
      chk(d, (i % 2 == 0) ? 32'h20 : 32'h0);
      wr(ctl(i), 32'h0);
    end
    rd(8'h60, d);
    chk(rsp, `TCC_RESP_SLVERR);
    wr(8'h60, 32'h0);
    chk(rsp, `TCC_RESP_SLVERR);
    wr(ctl(1), 32'h1C);
    chk(rsp, `TCC_RESP_OKAY);
    settle(3);
    chk(pin_oe[1], 1'b1);
    wr(ctl(0), 32'h20);
    settle(3);
    chk(pin_oe[1], 1'b0);
    wr(ctl(0), 32'h0);
    wr(ctl(1), 32'h0);
    // Falling edge, rising edge, and rising edge while halted.
    for (int e = 1; e < 4; e++) begin
      for (int k = 0; k < 3; k++) begin
        drive <= {(NCH-1)'($random(seed)), k == 0};
        wr(TC, 32'h30);
        wr(ctl(0), 32'h40 | (e << 2));
        wr(TC, (k == 2) ? 32'h20 : 32'h0);
        rd(ctl(0), d);
        wr(ctl(0), d & 32'h7F);
        @(posedge aclk);
        drive[0] <= (k != 0);
        settle(8);
        rd(ctl(0), d);
        chk(d[7], hit(e, k));
        chk(irq[0], hit(e, k));
        wr(ctl(0), d & 32'hBF);
        settle(2);
        chk(irq[0], 1'b0);
        rd(ctl(0), d);
        chk(d[7], hit(e, k));
        wr(ctl(0), d & 32'h7F);
        rd(ctl(0), d);
        chk(d[7], 1'b0);
      end
    end
    // A high-byte read holds off captures until the low byte is read.
    wr(TC, 32'h30);
    wr(ctl(0), 32'h0C);
    wr(TC, 32'h0);
    rd(ctl(0), d);
    wr(ctl(0), d & 32'h7F);
    for (int r = 0; r < 2; r++) begin
      rd(vh(0) + 8'(4 * r), d);
      drive[0] <= ~drive[0];
      settle(8);
      rd(ctl(0), d);
      chk(d[7], r[0]);
    end
    // Preset level, then clear or set on a random compare value.
    wr(`TCC_OFS_MOD, 32'h3F);
    for (int e = 2; e < 4; e++) begin
      v = 16'h000A + 16'($unsigned($random(seed)) % 40);
      wr(TC, 32'h30);
      wr(vh(2), {24'h0, v[15:8]});
      wr(vh(2) + 8'h04, {24'h0, v[7:0]});
      wr(ctl(2), e[0] ? 32'h10 : 32'h0);
      settle(3);
      chk(pin_out[2], !e[0]);
      chk(pin_oe[2], 1'b0);
      wr(ctl(2), 32'h10 | (e << 2));
      settle(3);
      chk(pin_oe[2], 1'b1);
      rd(ctl(2), d);
      wr(ctl(2), d & 32'h7F);
      wr(TC, 32'h0);
      settle(70);
      chk(pin_out[2], e[0]);
      rd(ctl(2), d);
      chk(d[7], 1'b1);
      rd(vh(2) + 8'h04, d);
      chk(d, {24'h0, v[7:0]});
    end
    // A lone high-byte write keeps matches off.
    wr(TC, 32'h30);
    rd(ctl(2), d);
    wr(ctl(2), d & 32'h7F);
    wr(vh(2), {24'h0, v[15:8]});
    wr(TC, 32'h0);
    settle(140);
    rd(ctl(2), d);
    chk(d[7], 1'b0);
    // Overflow toggles, also against a match on the same count.
    for (int t = 0; t < 2; t++) begin
      v = t ? 16'h003F : 16'hFFFF;
      wr(TC, 32'h30);
      wr(vh(4), {24'h0, v[15:8]});
      wr(vh(4) + 8'h04, {24'h0, v[7:0]});
      wr(ctl(4), t ? 32'h1E : 32'h1A);
      wr(TC, 32'h0);
      settle(10);
      p = pin_out[4];
      settle(64);
      chk(pin_out[4], !p);
      settle(64);
      chk(pin_out[4], p);
    end
    // Full duty holds the pin high for whole periods.
    wr(vh(4) + 8'h04, 32'h20);
    wr(ctl(4), 32'h1B);
    settle(130);
    n = 0;
    repeat (64) begin
      settle(1);
      n += (pin_out[4] === 1'b1);
    end
    chk(n, 64);
    // Buffered compare: only every second period uses the own value.
    wr(TC, 32'h30);
    wr(vh(4), 32'h0);
    wr(vh(4) + 8'h04, 32'h10);
    wr(vh(5), 32'hFF);
    wr(vh(5) + 8'h04, 32'hFF);
    wr(ctl(4), 32'h24);
    wr(TC, 32'h0);
    settle(30);
    p = pin_out[4];
    settle(128);
    chk(pin_out[4], !p);
    chk(pin_oe[5], 1'b0);
    results();
  end
  // Watchdog: the sequence needs far fewer than 20000 cycles.
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    results();
  end
endmodule
bind tcc_top tcc_top_monitor #(.NCH(NCH)) tcc_top_monitor_inst (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .channel_pin_out(channel_pin_out), .channel_pin_oe(channel_pin_oe),
  .channel_irq(channel_irq));
